// >>> src/gpb_pkg.sv
/*
 * Constants shared by the port bank: register indices, configuration
 * field positions and reset values.
 * Assumes a classic Wishbone slave with 32-bit data; the byte address of
 * a register is four times its index.
 */
`default_nettype none

package gpb_pkg;

    // Register indices.
    localparam logic [7:0] IDX_BANK_FIVE = 8'h4F;
    localparam logic [7:0] IDX_BANK_SIX = 8'h50;
    localparam logic [7:0] IDX_CFG_BASE = 8'h30;

    // Pin counts: bank five is full, bank six carries three pins.
    localparam int BANK_WIDTH = 8;
    localparam int BANK_SIX_PINS = 3;
    localparam int NUM_PINS = BANK_WIDTH + BANK_SIX_PINS;

    // Configuration register fields.
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_ALT_BIT = 2;
    localparam int CFG_EDGE_BIT = 3;
    localparam int CFG_ODRAIN_BIT = 7;

    // Reset values: every pin comes up as a non-inverted input.
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic DATA_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// >>> src/gpb_pin_cell.sv
/*
 * Combinational behaviour of one port pin: drive value and enable,
 * host read value and the level handed to the alternate function.
 * Assumes pin_level_in is already synchronised; outputs are registered
 * by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_cell #(
    parameter bit IS_SMI = 1'b0,
    parameter bit IS_KBD = 1'b0,
    parameter bit NO_ALT_POL = 1'b0,
    parameter bit HAS_EDGE = 1'b0
) (
    input wire logic [7:0] cfg_in,
    input wire logic data_in,
    input wire logic pin_level_in,
    input wire logic alt_out_in,
    input wire logic alt_oe_in,
    output logic drive_val_out,
    output logic drive_en_out,
    output logic is_input_out,
    output logic read_val_out,
    output logic alt_level_out
);

    wire logic edge_mode;
    wire logic alt_mode;
    wire logic pol_pin;
    wire logic src_val;
    wire logic pin_val;
    wire logic odrain;
    wire logic want_drive;

    // In either-edge mode direction and driver type stop acting; polarity acts only on the data bit.
    assign edge_mode = HAS_EDGE && cfg_in[gpb_pkg::CFG_EDGE_BIT];
    assign alt_mode = cfg_in[gpb_pkg::CFG_ALT_BIT] && !edge_mode;
    assign is_input_out = cfg_in[gpb_pkg::CFG_DIR_BIT] || edge_mode;
    assign pol_pin = cfg_in[gpb_pkg::CFG_POL_BIT] && !edge_mode
        && !(alt_mode && NO_ALT_POL);
    assign src_val = alt_mode ? alt_out_in : data_in;
    assign pin_val = src_val ^ pol_pin;
    // Keyboard lines are open drain in alternate mode so the far end can pull them too.
    assign odrain = (cfg_in[gpb_pkg::CFG_ODRAIN_BIT]
        && (!alt_mode || IS_SMI)) || (alt_mode && IS_KBD);
    assign want_drive = alt_mode ? alt_oe_in : !is_input_out;
    assign drive_val_out = odrain ? 1'b0 : pin_val;
    assign drive_en_out = want_drive && (!odrain || !pin_val);
    // The polarity bit still shapes the data bit in either-edge mode.
    assign read_val_out = is_input_out
        ? (pin_level_in ^ cfg_in[gpb_pkg::CFG_POL_BIT])
        : data_in;
    // Either-edge logic sees the raw pin; polarity shapes only the data bit.
    assign alt_level_out = pin_level_in ^ (cfg_in[gpb_pkg::CFG_POL_BIT]
        && !NO_ALT_POL && !edge_mode);

endmodule // gpb_pin_cell

`default_nettype wire

// >>> src/gpb_port_bank.sv
/*
 * Port bank with two shared data registers and one configuration
 * register per pin, reached over a classic Wishbone slave.
 * Assumes pins arrive asynchronously and that the board resolves each
 * pin from pin_out and pin_oe; alternate functions sit outside.
 */
`timescale 1ns/1ps
`default_nettype none

module gpb_port_bank #(
    parameter int ADDR_W = 10,
    parameter logic [10:0] SMI_MASK = 11'h000,
    parameter logic [10:0] KBD_MASK = 11'h400,
    parameter logic [10:0] DENSITY_MASK = 11'h000,
    parameter logic [10:0] EDGE_MASK = 11'h300
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_oe_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] alt_out_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] alt_oe_in,
    output logic [gpb_pkg::NUM_PINS-1:0] alt_level_out
);

    localparam int NP = gpb_pkg::NUM_PINS;
    localparam int BW = gpb_pkg::BANK_WIDTH;

    logic [7:0] cfg_reg [NP];
    logic [NP-1:0] data_reg;
    logic [NP-1:0] pin_meta_reg;
    logic [NP-1:0] pin_sync_reg;
    logic [NP-1:0] pin_out_reg;
    logic [NP-1:0] pin_oe_reg;
    logic [NP-1:0] alt_level_reg;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;

    wire logic [7:0] reg_idx;
    wire logic req;
    wire logic wr_lane0;
    wire logic hit_five;
    wire logic hit_six;
    wire logic [NP-1:0] cfg_hit;
    wire logic [NP-1:0] drive_val;
    wire logic [NP-1:0] drive_en;
    wire logic [NP-1:0] is_input;
    wire logic [NP-1:0] read_val;
    wire logic [NP-1:0] alt_level;
    wire logic [7:0] bank_five_rd;
    wire logic [7:0] bank_six_rd;
    wire logic [7:0] cfg_rd [NP];
    wire logic [7:0] cfg_sel_rd;
    wire logic [31:0] rd_word;

    // Register index is the word address; byte lanes beyond 0 are unused.
    assign reg_idx = 8'(wb_adr_in[ADDR_W-1:2]);
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_reg;
    assign wr_lane0 = req && wb_we_in && wb_sel_in[0];
    assign hit_five = (reg_idx == gpb_pkg::IDX_BANK_FIVE);
    assign hit_six = (reg_idx == gpb_pkg::IDX_BANK_SIX);

    // Bank six carries only three pins; its upper bits read as zero.
    assign bank_five_rd = read_val[BW-1:0];
    assign bank_six_rd = {{(BW - gpb_pkg::BANK_SIX_PINS){1'b0}},
        read_val[NP-1:BW]};

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pin
            wire logic [7:0] this_idx;
            wire logic bank_hit;
            wire logic [7:0] wr_byte;
            wire logic store_bit;

            assign this_idx = gpb_pkg::IDX_CFG_BASE + 8'(gi);
            assign cfg_hit[gi] = (reg_idx == this_idx);
            assign cfg_rd[gi] = cfg_hit[gi] ? cfg_reg[gi] : 8'h00;
            assign bank_hit = (gi < BW) ? hit_five : hit_six;
            assign wr_byte = wb_dat_in[7:0];
            assign store_bit = wr_byte[gi % BW];

            gpb_pin_cell #(
                .IS_SMI(SMI_MASK[gi]),
                .IS_KBD(KBD_MASK[gi]),
                .NO_ALT_POL(DENSITY_MASK[gi]),
                .HAS_EDGE(EDGE_MASK[gi])
            ) u_cell (
                .cfg_in(cfg_reg[gi]),
                .data_in(data_reg[gi]),
                .pin_level_in(pin_sync_reg[gi]),
                .alt_out_in(alt_out_in[gi]),
                .alt_oe_in(alt_oe_in[gi]),
                .drive_val_out(drive_val[gi]),
                .drive_en_out(drive_en[gi]),
                .is_input_out(is_input[gi]),
                .read_val_out(read_val[gi]),
                .alt_level_out(alt_level[gi])
            );

            always_ff @(posedge sys_clk_in) begin
                if (!rst_n_in) begin
                    cfg_reg[gi] <= gpb_pkg::CFG_RESET;
                end else if (wr_lane0 && cfg_hit[gi]) begin
                    cfg_reg[gi] <= wr_byte;
                end
            end

            // Input pins ignore data writes so the pin never moves.
            always_ff @(posedge sys_clk_in) begin
                if (!rst_n_in) begin
                    data_reg[gi] <= gpb_pkg::DATA_RESET;
                end else if (wr_lane0 && bank_hit && !is_input[gi]) begin
                    data_reg[gi] <= store_bit;
                end
            end
        end
    endgenerate

    // Only one configuration register can be hit, so OR-ing is a select.
    generate
        genvar gj;
        wire logic [7:0] cfg_acc [NP+1];
        assign cfg_acc[0] = 8'h00;
        for (gj = 0; gj < NP; gj++) begin : g_cfg_or
            assign cfg_acc[gj+1] = cfg_acc[gj] | cfg_rd[gj];
        end
        assign cfg_sel_rd = cfg_acc[NP];
    endgenerate

    // Unmapped indices answer with zero rather than stalling the bus.
    assign rd_word = hit_five ? {24'h00_0000, bank_five_rd}
        : hit_six ? {24'h00_0000, bank_six_rd}
        : {24'h00_0000, cfg_sel_rd};

    // Pins are asynchronous to the bus clock; the first stage feeds
    // nothing but the second.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Pin drive is registered so every top output leaves a flip-flop,
    // at the cost of one cycle between a write and the pin.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            alt_level_reg <= '0;
        end else begin
            pin_out_reg <= drive_val;
            pin_oe_reg <= drive_en;
            alt_level_reg <= alt_level;
        end
    end

    // Single-cycle classic slave: ack one cycle after the strobe, then
    // low for a cycle so a held strobe is not taken twice.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= gpb_pkg::RDATA_RESET;
        end else begin
            wb_ack_reg <= req;
            if (req && !wb_we_in) begin
                wb_dat_reg <= rd_word;
            end
        end
    end

    assign wb_ack_out = wb_ack_reg;
    assign wb_dat_out = wb_dat_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_out = pin_oe_reg;
    assign alt_level_out = alt_level_reg;

endmodule // gpb_port_bank

`default_nettype wire

// >>> bench/gpb_board.sv
/*
 * Board model for the port bank pins: resolves each pin level.
 * Assumes every pin carries a pull-up and an optional external driver.
 */
`timescale 1ns/1ps
`default_nettype none
module gpb_board (
    input wire logic [gpb_pkg::NUM_PINS-1:0] drv_val_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] drv_en_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] ext_en_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] ext_val_in,
    output logic [gpb_pkg::NUM_PINS-1:0] level_out
);
    // A released open-drain pin floats up, so released means high.
    assign level_out = (drv_en_in & drv_val_in) |
        (~drv_en_in & ext_en_in & ext_val_in) |
        (~drv_en_in & ~ext_en_in);
endmodule // gpb_board
`default_nettype wire

// >>> bench/gpb_port_bank_sva.sv
/*
 * Port-level checks of the port bank.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module gpb_port_bank_chk #(
    parameter int ADDR_W = 10
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_oe_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] alt_out_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] alt_oe_in
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_taken;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    // Alternate inputs can move the pins too, so only quiet spans count.
    sequence s_alt_quiet;
        ((alt_oe_in | alt_out_in) == '0) [*3];
    endsequence
    chk_ack_answer: assert property (s_taken |=> wb_ack_out)
        else $error("ack missing after a request");
    chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_out) |->
        $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
    chk_lane_zero: assert property (wb_dat_out[31:8] == 24'h0)
        else $error("read data above lane zero");
    chk_read_hold: assert property (!wb_ack_out |->
        $stable(wb_dat_out)) else $error("read data moved without ack");
    chk_oe_cause: assert property (s_alt_quiet ##0
        $changed(pin_oe_out) |-> $past(wb_ack_out && wb_we_in))
        else $error("pin enable moved without a write");
    chk_out_cause: assert property (s_alt_quiet ##0
        $changed(pin_out) |-> $past(wb_ack_out && wb_we_in))
        else $error("pin value moved without a write");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !rst_n_in |=> pin_oe_out == '0 && !wb_ack_out)
        else $error("pins or ack active after reset");
endmodule // gpb_port_bank_chk
bind gpb_port_bank gpb_port_bank_chk #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .alt_out_in(alt_out_in), .alt_oe_in(alt_oe_in));
`default_nettype wire

// >>> bench/test_gpb_port_bank.sv
/*
 * Self-checking bench for the port bank over classic Wishbone.
 * Assumes the board model resolves the pins; alternates are driven on a
 * few pins late in the run.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module test_gpb_port_bank;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [9:0] wb_adr = '0;
    logic [31:0] wb_wdat = '0;
    logic [31:0] rdat;
    logic ack;
    logic [10:0] p_out, p_oe, p_in, alt_lvl;
    logic [10:0] ext_en = '0;
    logic [10:0] ext_val = '0;
    logic [10:0] alt_o = '0;
    logic [10:0] alt_e = '0;
    logic [3:0] wb_sel = 4'hF;
    logic [10:0] x;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    logic [7:0] d;
    int bad_count = 0;
    int num_checks = 0;
    int seed = 28;
    // Pin 7 stands in for the interrupt output so its driver rule is seen.
    gpb_port_bank #(.SMI_MASK(11'h080)) dut (.sys_clk_in(sys_clk),
        .rst_n_in(rst_n),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .pin_in(p_in),
        .pin_out(p_out), .pin_oe_out(p_oe), .alt_out_in(alt_o),
        .alt_oe_in(alt_e), .alt_level_out(alt_lvl));
    gpb_board board (.drv_val_in(p_out), .drv_en_in(p_oe),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(p_in));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // For reads, val is the expected byte; for writes, the data.
    task automatic wb(input logic w, input logic [7:0] idx,
            input logic [7:0] val);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_wdat <= {24'h0, val};
        if (!w) exp_q.push_back({24'h0, val});
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic cfg_lo(input logic [7:0] v);
        for (int i = 0; i < 8; i++) wb(1'b1, 8'(8'h30 + i), v);
    endtask
    // Pins pass two sync stages and outputs lag a cycle; four is safe.
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    always @(posedge sys_clk) begin
        if (ack === 1'b1 && !wb_we) begin
            e = exp_q.pop_front();
            `CHK("read", e, rdat)
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) wb(1'b0, 8'(8'h30 + i), 8'h01);
        wb(1'b0, 8'h20, 8'h00);
        wb_sel <= 4'hE;
        wb(1'b1, 8'h38, 8'h00);
        wb_sel <= 4'hF;
        wb(1'b0, 8'h38, 8'h01);
        ext_en <= 11'h7FF;
        ext_val <= 11'($random(seed));
        settle();
        wb(1'b0, 8'h4F, ext_val[7:0]);
        wb(1'b0, 8'h50, {5'h0, ext_val[10:8]});
        cfg_lo(8'h03);
        wb(1'b0, 8'h4F, ~ext_val[7:0]);
        wb(1'b1, 8'h4F, 8'hFF);
        settle();
        `CHK("oe input", 11'h000, p_oe)
        @(posedge sys_clk);
        ext_en <= 11'h700;
        d = 8'($random(seed));
        cfg_lo(8'h00);
        settle();
        `CHK("pin old", 11'h000, p_out)
        wb(1'b1, 8'h4F, d);
        settle();
        `CHK("pin push", {3'h0, d}, p_out)
        `CHK("oe push", 11'h0FF, p_oe)
        cfg_lo(8'h02);
        settle();
        `CHK("pin inv", {3'h0, ~d}, p_out)
        wb(1'b0, 8'h4F, d);
        cfg_lo(8'h80);
        settle();
        `CHK("pin drain", 11'h000, p_out)
        `CHK("oe drain", {3'h0, ~d}, p_oe)
        @(posedge sys_clk);
        alt_o <= 11'($random(seed));
        alt_e <= 11'h4C0;
        wb(1'b1, 8'h36, 8'h86);
        wb(1'b1, 8'h37, 8'h86);
        wb(1'b1, 8'h39, 8'h8A);
        wb(1'b1, 8'h3A, 8'h04);
        wb(1'b0, 8'h50, {6'h0, ~ext_val[9], ext_val[8]});
        settle();
        x = {~alt_o[10], 2'h0, alt_o[7], 1'b1, ~d[5:0]};
        `CHK("oe alt", x, p_oe)
        x = {4'h0, ~alt_o[6], 6'h00};
        `CHK("pin alt", x, p_out)
        x = {alt_o[10] & ext_val[10], ext_val[9:8], alt_o[7:6], d[5:0]};
        `CHK("alt level", x, alt_lvl)
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wb(1'b0, 8'h37, 8'h01);
        settle();
        `CHK("oe reset", 11'h000, p_oe)
        `CHK("queue", 0, exp_q.size())
        final_report();
    end
endmodule // test_gpb_port_bank
`default_nettype wire
